// File: rtl/wol_frame_monitor.sv
// What this block does
// - level-clear write drops held level indication
// - pulse length field picks 8/16/32/64 cycles
// - pulse length ignored in level mode
// - bit 8 selects level or pulse
// - bit 7 enables wake detection
// - bit 5 enables password checking
// - bit 1 enables pattern interrupt
// - bit 0 enables wake packet interrupt
// - status bit 12 selects interrupt source
// - enabling wake sets interrupt source bit
// - status bit 7 latches delimiter error
// - status bit 6 latches bad CRC
// - status bit 5 latches password mismatch
// - status bit 1 latches pattern match
// - status bit 0 latches wake packet
// - match word holds bytes 4 and 5
// - CRC gate suppresses indications on bad CRC
// - delimiter search 0xD5 or 0x5D
// - six-byte password, writable, resets zero
module wol_frame_monitor
	import wol_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [15:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [3:0]  i_pstrb,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_frame_end,
	input  wire logic        i_sfd_err,
	input  wire logic        i_crc_bad,
	input  wire logic        i_pkt_seen,
	input  wire logic        i_pat_seen,
	input  wire logic [47:0] i_pkt_pwd,
	input  wire logic        i_pol_irq,
	output logic      [7:0]  o_sfd_value,
	output logic      [47:0] o_dest_match,
	output logic             o_wake,
	output logic             o_irq_bit1
);
	logic [15:0] cfg_q;
	logic [15:0] status_q;
	logic [15:0] dam1_q;
	logic [15:0] dam2_q;
	logic [15:0] dam3_q;
	logic [15:0] pwd_q [3];
	logic        level_q;
	logic        wake_irq_q;
	logic [31:0] rdata_q;
	logic        pulse_busy;
	logic        ind_start;
	logic [6:0]  plen;
	wol_ind_t    ind_state_q;

	function automatic logic addr_is(input logic [15:0] a, input logic [11:0] idx);
		return a[15:ADDR_LSB] == {2'b00, idx} && a[1:0] == 2'b00;
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	logic setup_ok;
	logic wr_acc;
	logic rd_acc;
	logic mapped;
	logic wr_cfg;
	logic wr_status;
	logic rd_status;

	assign setup_ok = i_psel && i_penable;
	assign wr_acc   = setup_ok && i_pwrite;
	assign rd_acc   = setup_ok && !i_pwrite;
	assign mapped   = addr_is(i_paddr, IDX_CFG) || addr_is(i_paddr, IDX_STATUS)
		|| addr_is(i_paddr, IDX_DAM1) || addr_is(i_paddr, IDX_DAM2)
		|| addr_is(i_paddr, IDX_DAM3) || addr_is(i_paddr, IDX_PWD1)
		|| addr_is(i_paddr, IDX_PWD2) || addr_is(i_paddr, IDX_PWD3);
	assign wr_cfg    = wr_acc && addr_is(i_paddr, IDX_CFG);
	assign wr_status = wr_acc && addr_is(i_paddr, IDX_STATUS);
	assign rd_status = rd_acc && addr_is(i_paddr, IDX_STATUS);

	// zero wait states; unmapped addresses answer with an error
	assign o_pready  = 1'b1;
	assign o_pslverr = setup_ok && !mapped;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cfg_q <= CFG_RESET;
		end else if (wr_cfg) begin
			// level-clear bit is write-only and never stored
			cfg_q <= merge(cfg_q, i_pwdata, i_pstrb) & CFG_WMASK;
		end
	end

	// match and password words, reset to zero
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			dam1_q <= MATCH_RESET;
			dam2_q <= MATCH_RESET;
			dam3_q <= MATCH_RESET;
		end else if (wr_acc) begin
			if (addr_is(i_paddr, IDX_DAM1)) dam1_q <= merge(dam1_q, i_pwdata, i_pstrb);
			if (addr_is(i_paddr, IDX_DAM2)) dam2_q <= merge(dam2_q, i_pwdata, i_pstrb);
			if (addr_is(i_paddr, IDX_DAM3)) dam3_q <= merge(dam3_q, i_pwdata, i_pstrb);
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_pwd
			always_ff @(posedge i_clk or negedge i_rst_b) begin
				if (!i_rst_b) begin
					pwd_q[g] <= MATCH_RESET;
				end else if (wr_acc && addr_is(i_paddr, IDX_PWD1 + 12'(g))) begin
					pwd_q[g] <= merge(pwd_q[g], i_pwdata, i_pstrb);
				end
			end
		end
	endgenerate

	// byte order: dest bytes 0..5 from word3, word2, word1
	assign o_dest_match = {dam3_q, dam2_q, dam1_q};
	assign o_sfd_value  = cfg_q[CFG_SFD_ALT] ? SFD_ALT : SFD_NORMAL;

	// frame events, qualified at frame end
	logic wake_en;
	logic gated;
	logic pwd_bad;
	logic pkt_ok;
	logic pat_ok;
	logic [47:0] pwd_cfg;

	assign wake_en = cfg_q[CFG_WAKE_EN];
	assign pwd_cfg = {pwd_q[2][7:0], pwd_q[2][15:8], pwd_q[1][7:0], pwd_q[1][15:8],
		pwd_q[0][7:0], pwd_q[0][15:8]};
	assign gated   = cfg_q[CFG_CRC_GATE] && i_crc_bad;
	assign pwd_bad = cfg_q[CFG_PWD_EN] && i_pkt_seen && (i_pkt_pwd != pwd_cfg);
	assign pkt_ok  = wake_en && i_frame_end && i_pkt_seen && !gated && !pwd_bad;
	assign pat_ok  = wake_en && i_frame_end && i_pat_seen && !gated;

	logic [15:0] set_mask;
	always_comb begin
		set_mask = 16'h0000;
		if (wake_en && i_frame_end) begin
			set_mask[ST_SFD_ERR] = i_sfd_err;
			set_mask[ST_BAD_CRC] = i_crc_bad;
			set_mask[ST_PWD_BAD] = pwd_bad && !gated;
		end
		set_mask[ST_PAT] = pat_ok;
		set_mask[ST_PKT] = pkt_ok;
	end

	// flags: set wins over clear-on-read so no event is lost
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			status_q <= STATUS_RESET;
		end else begin
			for (int b = 0; b < 12; b++) begin
				if (set_mask[b]) begin
					status_q[b] <= 1'b1;
				end else if (rd_status) begin
					status_q[b] <= 1'b0;
				end
			end
			if (wr_cfg && i_pstrb[0] && i_pwdata[CFG_WAKE_EN]) begin
				status_q[ST_INT_SRC] <= 1'b1;
			end else if (wr_status && i_pstrb[1]) begin
				status_q[ST_INT_SRC] <= i_pwdata[ST_INT_SRC];
			end
		end
	end

	// interrupt-worthy events per enable
	logic wake_evt;
	assign wake_evt = (pat_ok && cfg_q[CFG_PAT_IE])
		|| (pkt_ok && cfg_q[CFG_PKT_IE]);

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wake_irq_q <= 1'b0;
		end else begin
			wake_irq_q <= wake_evt;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_irq_bit1 <= 1'b0;
		end else begin
			o_irq_bit1 <= status_q[ST_INT_SRC] ? wake_irq_q : i_pol_irq;
		end
	end

	// indication: pulse or held level
	always_comb begin
		case (cfg_q[CFG_PLEN_HI:CFG_PLEN_LO])
			2'b00:   plen = PLEN_8;
			2'b01:   plen = PLEN_16;
			2'b10:   plen = PLEN_32;
			2'b11:   plen = PLEN_64;
			default: plen = PLEN_8;
		endcase
	end

	assign ind_start = wake_evt && !cfg_q[CFG_IND_LEVEL];

	wol_pulse_timer u_timer (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_start (ind_start),
		.i_len   (plen),
		.o_busy  (pulse_busy)
	);

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			level_q <= 1'b0;
		end else if (wake_evt && cfg_q[CFG_IND_LEVEL]) begin
			level_q <= 1'b1;
		end else if (wr_cfg && i_pstrb[1] && i_pwdata[CFG_LVL_CLR]) begin
			level_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ind_state_q <= WOL_IND_IDLE;
		end else begin
			case (ind_state_q)
				WOL_IND_IDLE:  ind_state_q <= ind_start ? WOL_IND_PULSE
					: (level_q ? WOL_IND_LEVEL : WOL_IND_IDLE);
				WOL_IND_PULSE: ind_state_q <= pulse_busy ? WOL_IND_PULSE : WOL_IND_IDLE;
				WOL_IND_LEVEL: ind_state_q <= level_q ? WOL_IND_LEVEL : WOL_IND_IDLE;
				default:       ind_state_q <= WOL_IND_IDLE;
			endcase
		end
	end

	assign o_wake = pulse_busy || level_q;

	// read data not registered, decoded combinationally during the access for zero wait
	always_comb begin
		rdata_q = 32'h0000_0000;
		if (rd_acc) begin
			if (addr_is(i_paddr, IDX_CFG))    rdata_q = {16'h0000, cfg_q};
			if (addr_is(i_paddr, IDX_STATUS)) rdata_q = {16'h0000, status_q};
			if (addr_is(i_paddr, IDX_DAM1))   rdata_q = {16'h0000, dam1_q};
			if (addr_is(i_paddr, IDX_DAM2))   rdata_q = {16'h0000, dam2_q};
			if (addr_is(i_paddr, IDX_DAM3))   rdata_q = {16'h0000, dam3_q};
			if (addr_is(i_paddr, IDX_PWD1))   rdata_q = {16'h0000, pwd_q[0]};
			if (addr_is(i_paddr, IDX_PWD2))   rdata_q = {16'h0000, pwd_q[1]};
			if (addr_is(i_paddr, IDX_PWD3))   rdata_q = {16'h0000, pwd_q[2]};
		end
	end
	assign o_prdata = rdata_q;
endmodule

// File: rtl/wol_pkg.sv
package wol_pkg;
	// register indices; byte address is four times the index
	localparam logic [11:0] IDX_CFG     = 12'h4a0;
	localparam logic [11:0] IDX_STATUS  = 12'h4a1;
	localparam logic [11:0] IDX_DAM1    = 12'h4a2;
	localparam logic [11:0] IDX_DAM2    = 12'h4a3;
	localparam logic [11:0] IDX_DAM3    = 12'h4a4;
	localparam logic [11:0] IDX_PWD1    = 12'h4a5;
	localparam logic [11:0] IDX_PWD2    = 12'h4a6;
	localparam logic [11:0] IDX_PWD3    = 12'h4a7;
	localparam int          ADDR_LSB    = 2;

	// configuration fields
	localparam int CFG_LVL_CLR   = 11;
	localparam int CFG_PLEN_HI   = 10;
	localparam int CFG_PLEN_LO   = 9;
	localparam int CFG_IND_LEVEL = 8;
	localparam int CFG_WAKE_EN   = 7;
	localparam int CFG_PWD_EN    = 5;
	localparam int CFG_PAT_IE    = 1;
	localparam int CFG_PKT_IE    = 0;
	localparam int CFG_SFD_ALT   = 13;
	localparam int CFG_CRC_GATE  = 12;
	localparam logic [15:0] CFG_RESET  = 16'h1000;
	localparam logic [15:0] CFG_WMASK  = 16'hf7ff;

	// status fields
	localparam int ST_INT_SRC  = 12;
	localparam int ST_SFD_ERR  = 7;
	localparam int ST_BAD_CRC  = 6;
	localparam int ST_PWD_BAD  = 5;
	localparam int ST_PAT      = 1;
	localparam int ST_PKT      = 0;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [15:0] MATCH_RESET  = 16'h0000;

	localparam logic [7:0] SFD_NORMAL = 8'hd5;
	localparam logic [7:0] SFD_ALT    = 8'h5d;

	// wake pulse length in wake-clock cycles, per field code
	localparam logic [6:0] PLEN_8  = 7'h08;
	localparam logic [6:0] PLEN_16 = 7'h10;
	localparam logic [6:0] PLEN_32 = 7'h20;
	localparam logic [6:0] PLEN_64 = 7'h40;
	localparam int         WAKE_CLK_MHZ = 125;
	localparam int         SYS_CLK_MHZ  = 50;

	typedef enum logic [1:0] {
		WOL_IND_IDLE  = 2'b00,
		WOL_IND_PULSE = 2'b01,
		WOL_IND_LEVEL = 2'b10
	} wol_ind_t;
endpackage

// File: rtl/wol_pulse_timer.sv
// counts wake-clock ticks; each system cycle stands for 125/50 ticks,
// so the length is converted with an accumulator instead of a second clock
module wol_pulse_timer
	import wol_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_start,
	input  wire logic [6:0] i_len,
	output logic            o_busy
);
	// 64 ticks scaled by 50 needs 12 bits
	logic [11:0] ticks_q;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ticks_q <= 12'h000;
		end else if (i_start) begin
			ticks_q <= {5'b00000, i_len} * 12'(SYS_CLK_MHZ);
		end else if (ticks_q > 12'(WAKE_CLK_MHZ)) begin
			ticks_q <= ticks_q - 12'(WAKE_CLK_MHZ);
		end else begin
			ticks_q <= 12'h000;
		end
	end

	// ticks scaled by 50; each cycle removes 125 scaled units
	assign o_busy = (ticks_q != 12'h000);
endmodule

// File: tb/test_wol_frame_monitor.sv
module test_wol_frame_monitor;
	timeunit 1ns;
	timeprecision 1ns;
	logic		i_clk, i_rst_b, psel, pen, pwr, pol, ready, slv, fend, wake, irq;
	logic [15:0]	paddr;
	logic [31:0]	pwdata, prdata, r;
	logic [3:0]	res;
	logic [47:0]	ppwd;
	logic [7:0]	sfdv;
	logic		se;
	logic [47:0]	dmatch;
	int		err_total, n_compared, cyc, n;
	int		lens[4] = '{4, 7, 13, 26};
	logic [3:0]	fr[3] = '{4'h8, 4'h6, 4'h1};
	logic [31:0]	ex[3] = '{32'h1080, 32'h1040, 32'h1002};
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	wol_frame_monitor i_wol_frame_monitor (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
		.i_pwdata(pwdata), .i_pstrb(4'hf), .o_prdata(prdata), .o_pready(ready),
		.o_pslverr(slv), .i_frame_end(fend), .i_sfd_err(res[3]), .i_crc_bad(res[2]),
		.i_pkt_seen(res[1]), .i_pat_seen(res[0]), .i_pkt_pwd(ppwd), .i_pol_irq(pol),
		.o_sfd_value(sfdv), .o_dest_match(dmatch), .o_wake(wake), .o_irq_bit1(irq));
	wol_remote_station i_wol_remote_station (.i_clk(i_clk), .o_frame_end(fend),
		.o_result(res), .o_pwd(ppwd));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
		@(posedge i_clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= {16'h0, d};
		pen <= 1'b0;
		@(posedge i_clk);
		pen <= 1'b1;
		// answer is taken at the edge that samples pready high
		do @(posedge i_clk); while (ready !== 1'b1);
		r = prdata;
		se = slv;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rc(input logic [15:0] a, input logic [31:0] e);
		acc(1'b0, a, 16'h0);
		chk(r, e);
	endtask
	task automatic cnt();
		n = 0;
		repeat (40) begin
			@(negedge i_clk);
			if (wake === 1'b1) n++;
		end
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// ceiling well above the roughly 420 cycles the sequence needs
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 6000) begin
			err_total++;
			tally_and_finish();
		end
	end
	initial begin
		{psel, pen, pwr, pol, i_rst_b} = '0;
		paddr = 16'h0;
		pwdata = 32'h0;
		repeat (8) @(posedge i_clk);
		i_rst_b <= 1'b1;
		rc(16'h1280, 32'h1000);
		for (int i = 1; i < 8; i++) rc(16'h1280 + 16'(4 * i), 32'h0);
		acc(1'b1, 16'h1288, 16'ha55a);
		rc(16'h1288, 32'ha55a);
		chk({16'h0, dmatch[47:32]}, 32'h0);
		chk(dmatch[31:0], 32'h0000_a55a);
		for (int i = 0; i < 3; i++) begin
			acc(1'b1, 16'h1294 + 16'(4 * i), 16'h1234);
			rc(16'h1294 + 16'(4 * i), 32'h1234);
		end
		acc(1'b0, 16'h12a0, 16'h0);
		chk({se, r[30:0]}, 32'h8000_0000);
		$display("register test done");
		acc(1'b1, 16'h1280, 16'h1001);
		i_wol_remote_station.send(4'h2, 48'h0);
		cnt();
		chk(n, 0);
		rc(16'h1284, 32'h0);
		for (int k = 0; k < 4; k++) begin
			acc(1'b1, 16'h1280, 16'h1081 | 16'(k << 9));
			i_wol_remote_station.send(4'h2, 48'h0);
			cnt();
			chk(n, lens[k]);
			rc(16'h1284, 32'h1001);
			rc(16'h1284, 32'h1000);
		end
		acc(1'b1, 16'h1284, 16'h0);
		pol <= 1'b1;
		repeat (3) @(negedge i_clk);
		chk(irq, 1);
		pol <= 1'b0;
		$display("pulse test done");
		acc(1'b1, 16'h1280, 16'h3781);
		@(negedge i_clk);
		chk(sfdv, 8'h5d);
		i_wol_remote_station.send(4'h2, 48'h0);
		cnt();
		chk(wake, 1);
		acc(1'b1, 16'h1280, 16'h3f81);
		@(negedge i_clk);
		chk(wake, 0);
		rc(16'h1280, 32'h3781);
		rc(16'h1284, 32'h1001);
		$display("level test done");
		acc(1'b1, 16'h1280, 16'h10a3);
		@(negedge i_clk);
		chk(sfdv, 8'hd5);
		i_wol_remote_station.send(4'h2, 48'h1);
		acc(1'b0, 16'h1284, 16'h0);
		chk(r & 32'h20, 32'h20);
		for (int i = 0; i < 3; i++) begin
			i_wol_remote_station.send(fr[i], 48'h0);
			rc(16'h1284, ex[i]);
		end
		i_wol_remote_station.send(4'h2, 48'h3412_3412_3412);
		rc(16'h1284, 32'h1001);
		acc(1'b1, 16'h1280, 16'h0083);
		i_wol_remote_station.send(4'h6, 48'h0);
		rc(16'h1284, 32'h1041);
		i_wol_remote_station.send(4'h2, 48'h1);
		rc(16'h1284, 32'h1001);
		$display("frame test done");
		tally_and_finish();
	end
endmodule

// File: tb/wol_frame_monitor_properties.sv
module wol_monitor_properties
	import wol_pkg::*;
(
	input	wire logic		i_clk,
	input	wire logic		i_rst_b,
	input	wire logic		i_psel,
	input	wire logic		i_penable,
	input	wire logic		i_pwrite,
	input	wire logic [15:0]	i_paddr,
	input	wire logic [31:0]	i_pwdata,
	input	wire logic		i_frame_end,
	input	wire logic		i_crc_bad,
	input	wire logic		i_pkt_seen,
	input	wire logic		i_pol_irq,
	input	wire logic [7:0]	o_sfd_value,
	input	wire logic		o_wake,
	input	wire logic		o_irq_bit1
);
	timeunit 1ns;
	timeprecision 1ns;
	logic		wr;
	logic		cfg_wr;
	logic [15:0]	cfg_q;
	logic		src_q;
	assign wr = i_psel & i_penable & i_pwrite;
	assign cfg_wr = wr && i_paddr == 16'h1280;
	// shadow copies, so assertions can see mode bits without peeking inside
	always_ff @(posedge i_clk or negedge i_rst_b)
		if (!i_rst_b) cfg_q <= CFG_RESET;
		else if (cfg_wr) cfg_q <= i_pwdata[15:0] & CFG_WMASK;
	always_ff @(posedge i_clk or negedge i_rst_b)
		if (!i_rst_b) src_q <= 1'b0;
		else if (cfg_wr && i_pwdata[7]) src_q <= 1'b1;
		else if (wr && i_paddr == 16'h1284) src_q <= i_pwdata[12];
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	chk_sfd_code: assert property (o_sfd_value == (cfg_q[13] ? 8'h5d : 8'hd5))
		else $error("delimiter value wrong");
	chk_pulse_len: assert property (!cfg_q[8] && cfg_q[10:9] == 2'b00 && $rose(o_wake)
		|-> o_wake[*4] ##1 !o_wake) else $error("short pulse length wrong");
	chk_wake_off: assert property (i_frame_end && !cfg_q[7] |=> !$rose(o_wake))
		else $error("wake raised while detection off");
	chk_level_hold: assert property (cfg_q[8] && o_wake && !cfg_wr |=> o_wake)
		else $error("level indication dropped");
	chk_level_clear: assert property (cfg_q[8] && cfg_wr && i_pwdata[11] && !i_frame_end
		|=> !o_wake) else $error("level not cleared");
	chk_irq_pol: assert property (!src_q |=> o_irq_bit1 == $past(i_pol_irq))
		else $error("polarity source not routed");
	chk_irq_wake: assert property (src_q && cfg_q[7] && cfg_q[0] && !cfg_q[5] && i_frame_end
		&& i_pkt_seen && !i_crc_bad |-> ##[1:3] o_irq_bit1) else $error("no wake irq");
	chk_crc_gate: assert property (cfg_q[12] && i_frame_end && i_crc_bad && !o_wake
		|=> !o_wake[*3]) else $error("bad frame indicated");
	cover property ($rose(o_wake));
	cover property ($fell(o_wake) && cfg_q[8]);
	cover property (i_frame_end && i_crc_bad && cfg_q[12]);
endmodule

bind wol_frame_monitor wol_monitor_properties i_wol_monitor_properties (
	.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
	.i_frame_end(i_frame_end), .i_crc_bad(i_crc_bad), .i_pkt_seen(i_pkt_seen),
	.i_pol_irq(i_pol_irq), .o_sfd_value(o_sfd_value), .o_wake(o_wake),
	.o_irq_bit1(o_irq_bit1));

// File: tb/wol_remote_station.sv
module wol_remote_station (
	input	wire logic		i_clk,
	output	logic			o_frame_end,
	output	logic [3:0]		o_result,
	output	logic [47:0]	o_pwd
);
	timeunit 1ns;
	timeprecision 1ns;
	// results mean nothing outside frame end, so they are scrambled there
	initial begin
		o_frame_end = 1'b0;
		o_result = 4'hf;
		o_pwd = '1;
	end
	task automatic send(input logic [3:0] r, input logic [47:0] p);
		@(posedge i_clk);
		o_frame_end <= 1'b1;
		o_result <= r;
		o_pwd <= p;
		@(posedge i_clk);
		o_frame_end <= 1'b0;
		o_result <= ~r;
		o_pwd <= ~p;
	endtask
endmodule
